// ==== core/sbcd_driver.sv ====
`timescale 1ns/1ps
// Commutation and gate drive for a sensorless three-phase motor
module sbcd_driver
    import sbcd_pkg::*;
#(
    parameter int OFF_W = OFF_CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Pins from the analogue side
    input wire logic commutation_clock_in,
    input wire logic overcurrent_trip,
    input wire logic brake_n,
    input wire logic undervoltage_lockout,
    input wire logic align_end,
    input wire logic ramp_end,
    input wire logic pwm_on,
    // Pins to the bridge and the analogue side
    output sbcd_gate_type gates,
    output sbcd_sense_type sense_select,
    output logic commutation_clock,
    output logic bemf_enable,
    output logic ramp_source_enable,
    output logic undervoltage_flag_n
);

    if (OFF_W < 2 || OFF_W > 16) begin : g_chk
        $error("sbcd_driver: OFF_W must be 2 to 16");
    end

    logic [SYN_N-1:0] syn1_r;
    logic [SYN_N-1:0] syn2_r;
    logic comm_prev_r;
    logic comm_edge;
    logic trip_s;
    logic brake_s;
    logic uv_s;
    logic pwm_s;
    logic restart_req;

    sbcd_comm_type state_r;
    sbcd_comm_type state_nxt;
    sbcd_mode_type mode_r;
    sbcd_mode_type mode_nxt;

    logic [31:0] ctrl_r;
    logic [OFF_W-1:0] off_time_r;
    logic [15:0] steps_r;
    logic [15:0] trips_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_mux;
    logic wr_take;

    logic limit_active;
    logic limit_fire;
    sbcd_gate_type decode_g;
    sbcd_gate_type gates_nxt;
    sbcd_gate_type gates_r;
    sbcd_sense_type sense_nxt;
    sbcd_sense_type sense_r;
    logic comm_out_r;
    logic bemf_en_r;
    logic ramp_en_r;
    logic uv_flag_n_r;

    // Two-flop synchronisers for every pin input
    for (genvar i = 0; i < SYN_N; i++) begin : g_sync
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                syn1_r[i] <= SYN_RST[i];
                syn2_r[i] <= SYN_RST[i];
            end else begin
                syn1_r[i] <= (i == SYN_COMM) ? commutation_clock_in :
                    (i == SYN_TRIP) ? overcurrent_trip :
                    (i == SYN_BRAKE_N) ? brake_n :
                    (i == SYN_UV) ? undervoltage_lockout :
                    (i == SYN_ALIGN_END) ? align_end :
                    (i == SYN_RAMP_END) ? ramp_end : pwm_on;
                syn2_r[i] <= syn1_r[i];
            end
        end
    end

    // Synchronised levels and software overrides
    assign trip_s = syn2_r[SYN_TRIP];
    assign uv_s = syn2_r[SYN_UV];
    assign pwm_s = syn2_r[SYN_PWM];
    assign brake_s = !syn2_r[SYN_BRAKE_N] || ctrl_r[CTRL_BRAKE_BIT];
    assign restart_req = wr_take && (address == ADDR_CONTROL)
        && writedata[CTRL_RESTART_BIT];

    // Rising edge of the commutation clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            comm_prev_r <= 1'b0;
        end else begin
            comm_prev_r <= syn2_r[SYN_COMM];
        end
    end

    assign comm_edge = syn2_r[SYN_COMM] && !comm_prev_r;

    // Start-up sequencing: align, open-loop ramp, then run
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MD_ALIGN: begin
                if (syn2_r[SYN_ALIGN_END]) begin
                    mode_nxt = MD_RAMP;
                end
            end
            MD_RAMP: begin
                if (syn2_r[SYN_RAMP_END]) begin
                    mode_nxt = MD_RUN;
                end
            end
            MD_RUN: begin
                mode_nxt = MD_RUN;
            end
            default: begin
                mode_nxt = MD_ALIGN;
            end
        endcase
        if (uv_s || restart_req) begin
            mode_nxt = MD_ALIGN;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MD_ALIGN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Six-step commutation, held at align until ramp begins
    always_comb begin
        state_nxt = state_r;
        if (mode_r == MD_ALIGN) begin
            state_nxt = ST_ALIGN;
        end else if (comm_edge) begin
            unique case (state_r)
                ST_ALIGN: state_nxt = ST_A;
                ST_A: state_nxt = ST_B;
                ST_B: state_nxt = ST_C;
                ST_C: state_nxt = ST_D;
                ST_D: state_nxt = ST_E;
                ST_E: state_nxt = ST_F;
                ST_F: state_nxt = ST_A;
                default: state_nxt = ST_ALIGN;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_ALIGN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Commutation steps taken since reset or the last clear; a step in the clearing cycle is kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            steps_r <= 16'h0000;
        end else if (wr_take && address == ADDR_STEPS) begin
            steps_r <= (state_nxt != state_r && state_nxt != ST_ALIGN)
                ? 16'h0001 : 16'h0000;
        end else if (state_nxt != state_r && state_nxt != ST_ALIGN) begin
            steps_r <= steps_r + 16'h0001;
        end
    end

    // State decode; high-side fields are active low
    always_comb begin
        decode_g = GATES_OFF;
        sense_nxt = '0;
        unique case (state_r)
            ST_ALIGN: begin
                decode_g.low_drive_b = 1'b1;
                decode_g.high_drive_n_a = 1'b0;
                decode_g.high_drive_n_c = 1'b0;
            end
            ST_A: begin
                decode_g.low_drive_c = 1'b1;
                decode_g.high_drive_n_a = 1'b0;
                sense_nxt.phase_sense_b = 1'b1;
            end
            ST_B: begin
                decode_g.low_drive_c = 1'b1;
                decode_g.high_drive_n_b = 1'b0;
                sense_nxt.phase_sense_a = 1'b1;
            end
            ST_C: begin
                decode_g.low_drive_a = 1'b1;
                decode_g.high_drive_n_b = 1'b0;
                sense_nxt.phase_sense_c = 1'b1;
            end
            ST_D: begin
                decode_g.low_drive_a = 1'b1;
                decode_g.high_drive_n_c = 1'b0;
                sense_nxt.phase_sense_b = 1'b1;
            end
            ST_E: begin
                decode_g.low_drive_b = 1'b1;
                decode_g.high_drive_n_c = 1'b0;
                sense_nxt.phase_sense_a = 1'b1;
            end
            ST_F: begin
                decode_g.low_drive_b = 1'b1;
                decode_g.high_drive_n_a = 1'b0;
                sense_nxt.phase_sense_c = 1'b1;
            end
            default: begin
                decode_g = GATES_OFF;
            end
        endcase
    end

    // Current-limit off-time one-shot
    sbcd_oneshot #(
        .CNT_W(OFF_W)
    ) u_oneshot (
        .clk(clk),
        .reset_n(reset_n),
        .trip(trip_s),
        .off_cycles(off_time_r),
        .active(limit_active),
        .fire(limit_fire)
    );

    // Final gate combination in priority order
    always_comb begin
        gates_nxt = decode_g;
        if (!pwm_s || limit_active) begin
            gates_nxt.low_drive_a = 1'b0;
            gates_nxt.low_drive_b = 1'b0;
            gates_nxt.low_drive_c = 1'b0;
        end
        if (brake_s) begin
            gates_nxt = GATES_BRAKE;
        end
        if (uv_s) begin
            gates_nxt = GATES_OFF;
        end
    end

    // Registered pin drive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gates_r <= GATES_OFF;
            sense_r <= '0;
        end else begin
            gates_r <= gates_nxt;
            sense_r <= sense_nxt;
        end
    end

    // Mode-derived analogue enables, commutation clock and undervoltage flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            comm_out_r <= 1'b0;
            bemf_en_r <= 1'b0;
            ramp_en_r <= 1'b0;
            uv_flag_n_r <= 1'b0;
        end else begin
            comm_out_r <= syn2_r[SYN_COMM];
            bemf_en_r <= (mode_nxt == MD_RUN);
            ramp_en_r <= (mode_nxt == MD_RAMP);
            uv_flag_n_r <= !uv_s;
        end
    end

    assign gates = gates_r;
    assign sense_select = sense_r;
    assign commutation_clock = comm_out_r;
    assign bemf_enable = bemf_en_r;
    assign ramp_source_enable = ramp_en_r;
    assign undervoltage_flag_n = uv_flag_n_r;

    // Bus handshake: one wait cycle per access
    assign waitrequest = (read || write) && !ack_r;
    assign wr_take = write && ack_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read || write) && !ack_r;
        end
    end

    // Control and off-time registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RST;
            off_time_r <= OFF_W'(OFF_TIME_RST);
        end else if (wr_take) begin
            if (address == ADDR_CONTROL) begin
                ctrl_r <= 32'(writedata[CTRL_BRAKE_BIT]);
            end
            if (address == ADDR_OFF_TIME) begin
                off_time_r <= writedata[OFF_W-1:0];
            end
        end
    end

    // Trip counter; a trip in the clearing cycle is kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trips_r <= 16'h0000;
        end else if (wr_take && address == ADDR_STEPS) begin
            trips_r <= limit_fire ? 16'h0001 : 16'h0000;
        end else if (limit_fire && trips_r != 16'hffff) begin
            trips_r <= trips_r + 16'h0001;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (address)
            ADDR_CONTROL: rd_mux = ctrl_r;
            ADDR_OFF_TIME: rd_mux = 32'(off_time_r);
            ADDR_STATUS: begin
                rd_mux[STAT_STATE_LSB +: 3] = state_r;
                rd_mux[STAT_MODE_LSB +: 2] = mode_r;
                rd_mux[STAT_UV_BIT] = uv_s;
                rd_mux[STAT_BRAKE_BIT] = brake_s;
                rd_mux[STAT_LIMIT_BIT] = limit_active;
                rd_mux[STAT_PWM_BIT] = pwm_s;
            end
            ADDR_STEPS: rd_mux = {trips_r, steps_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle, held for the answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && !ack_r) begin
            readdata_r <= rd_mux;
        end
    end

    assign readdata = readdata_r;

endmodule

// ==== core/sbcd_pkg.sv ====
package sbcd_pkg;

    // Clock and off-time figures
    localparam int CLK_PERIOD_NS = 50;
    localparam int OFF_TIME_NS = 20000;
    localparam int OFF_TIME_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int OFF_CNT_W = 16;
    localparam logic [15:0] OFF_TIME_RST = 16'(OFF_TIME_CYC);

    // Register byte offsets
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_OFF_TIME = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_STEPS = 4'hc;
    localparam logic [3:0] ADDR_TRIPS = 4'h0;

    // Control fields and reset value
    localparam int CTRL_BRAKE_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_UV_BIT = 8;
    localparam int STAT_BRAKE_BIT = 9;
    localparam int STAT_LIMIT_BIT = 10;
    localparam int STAT_PWM_BIT = 11;

    // Synchroniser lanes and their reset levels
    localparam int SYN_COMM = 0;
    localparam int SYN_TRIP = 1;
    localparam int SYN_BRAKE_N = 2;
    localparam int SYN_UV = 3;
    localparam int SYN_ALIGN_END = 4;
    localparam int SYN_RAMP_END = 5;
    localparam int SYN_PWM = 6;
    localparam int SYN_N = 7;
    localparam logic [6:0] SYN_RST = 7'h0c;

    typedef enum logic [2:0] {
        ST_ALIGN, ST_A, ST_B, ST_C, ST_D, ST_E, ST_F
    } sbcd_comm_type;

    typedef enum logic [1:0] {
        MD_ALIGN, MD_RAMP, MD_RUN
    } sbcd_mode_type;

    typedef struct packed {
        logic low_drive_a;
        logic low_drive_b;
        logic low_drive_c;
        logic high_drive_n_a;
        logic high_drive_n_b;
        logic high_drive_n_c;
    } sbcd_gate_type;

    typedef struct packed {
        logic phase_sense_a;
        logic phase_sense_b;
        logic phase_sense_c;
    } sbcd_sense_type;

    localparam sbcd_gate_type GATES_OFF = 6'h07;
    localparam sbcd_gate_type GATES_BRAKE = 6'h3f;

endpackage

// ==== core/sbcd_oneshot.sv ====
`timescale 1ns/1ps
// Fixed off-time one-shot for the current limit
module sbcd_oneshot
    import sbcd_pkg::*;
#(
    parameter int CNT_W = OFF_CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic trip,
    input wire logic [CNT_W-1:0] off_cycles,
    output logic active,
    output logic fire
);

    logic [CNT_W-1:0] count_r;

    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("sbcd_oneshot: CNT_W must be 2 to 32");
    end

    // Start only when idle; a held trip restarts after the period
    assign fire = trip && (count_r == '0);
    assign active = (count_r != '0);

    // Count down the off period, zero setting acts as one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (fire) begin
            count_r <= (off_cycles == '0) ? CNT_W'(1) : off_cycles;
        end else if (count_r != '0) begin
            count_r <= count_r - CNT_W'(1);
        end
    end

endmodule

// ==== testbench/sbcd_chk.sv ====
`timescale 1ns/1ps
// Port-level checks on the commutation driver
module sbcd_chk
    import sbcd_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic overcurrent_trip,
    input wire logic brake_n,
    input wire logic undervoltage_lockout,
    input wire logic pwm_on,
    input wire sbcd_gate_type gates,
    input wire sbcd_sense_type sense_select,
    input wire logic commutation_clock,
    input wire logic bemf_enable,
    input wire logic ramp_source_enable,
    input wire logic undervoltage_flag_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Gate safety and overrides
    AST_NO_SHOOT: assert property (
        (gates[5:3] & ~gates[2:0]) == 3'b000)
        else $error("low and high side of one phase both on");
    AST_UV_OFF: assert property (
        undervoltage_lockout[*4] |-> gates == GATES_OFF)
        else $error("gates not off in undervoltage");
    AST_UV_FLAG: assert property (
        undervoltage_lockout[*4] |-> !undervoltage_flag_n)
        else $error("undervoltage flag not low");
    AST_BRAKE: assert property (
        (!brake_n && !undervoltage_lockout)[*4] |-> gates == GATES_BRAKE)
        else $error("brake pattern missing");
    AST_PWM_GATE: assert property (
        (!pwm_on)[*4] |-> gates[5:3] == 3'b000 || gates == GATES_BRAKE)
        else $error("low side on during pwm off phase");
    AST_LIMIT_OFF: assert property (
        $rose(overcurrent_trip) |-> ##[2:4]
        (gates[5:3] == 3'b000 || gates == GATES_BRAKE))
        else $error("low sides not cut after trip");

    // Decode, stepping, modes and bus wait
    AST_SENSE_IDLE: assert property (
        gates != GATES_BRAKE |-> $onehot0(sense_select) &&
        ((gates[5:3] | ~gates[2:0]) & sense_select) == 3'b000)
        else $error("sampled phase is driven");
    AST_STEP_CHG: assert property (
        $rose(commutation_clock) && ramp_source_enable
        |-> ##[0:3] $changed(sense_select))
        else $error("no step after commutation edge");
    AST_STEP_HOLD: assert property (
        (ramp_source_enable && !commutation_clock)[*6]
        |-> $stable(sense_select))
        else $error("step without commutation edge");
    AST_MODE_EXCL: assert property (
        !(bemf_enable && ramp_source_enable))
        else $error("ramp and run both active");
    AST_ALIGN_SENSE: assert property (
        (!ramp_source_enable && !bemf_enable)[*3] |-> sense_select == 3'h0)
        else $error("phase sampled in align");
    AST_ONE_WAIT: assert property (
        $rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus wait not exactly one cycle");

    // Main scenarios reached
    COV_RUN: cover property (ramp_source_enable ##1 bemf_enable);
    COV_BRAKE: cover property (gates == GATES_BRAKE);
    COV_TRIP: cover property ($rose(overcurrent_trip));
endmodule

bind sbcd_driver sbcd_chk i_sbcd_chk (.clk, .reset_n, .read, .write,
    .waitrequest, .overcurrent_trip, .brake_n, .undervoltage_lockout,
    .pwm_on, .gates, .sense_select, .commutation_clock, .bemf_enable,
    .ramp_source_enable, .undervoltage_flag_n);

// ==== testbench/sbcd_bridge.sv ====
`timescale 1ns/1ps
// Bridge and motor: current only flows through a conducting low side
module sbcd_bridge
    import sbcd_pkg::*;
(
    input wire logic clk,
    input wire sbcd_gate_type gates,
    input wire logic overload,
    output logic overcurrent_trip,
    output int shoots
);
    // Sense comparator trips while overloaded and a low side is on
    assign overcurrent_trip = overload && (gates[5:3] != 3'b000);

    // Counts cycles where a phase would short the supply
    initial shoots = 0;
    always @(posedge clk) begin
        if ((gates[5:3] & ~gates[2:0]) != 3'b000) begin
            shoots <= shoots + 1;
        end
    end
endmodule

// ==== testbench/sensorless_bldc_commutation_driver_tb.sv ====
`timescale 1ns/1ps
module sensorless_bldc_commutation_driver_tb;
    logic clk = 0, reset_n = 0, read = 0, write = 0, waitrequest;
    logic commutation_clock_in = 0, brake_n = 1, overload = 0;
    logic undervoltage_lockout = 0, align_end = 0, ramp_end = 0;
    logic pwm_on = 1, overcurrent_trip, commutation_clock, bemf_enable;
    logic ramp_source_enable, undervoltage_flag_n;
    logic [3:0] address = 0;
    logic [31:0] writedata = 0, readdata, rd_cap, act;
    logic [5:0] gates;
    logic [2:0] sense_select;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [5:0] tbl[6] = '{6'h0b, 6'h0d, 6'h25, 6'h26, 6'h16, 6'h13};
    logic [2:0] sen[6] = '{3'h2, 3'h4, 3'h1, 3'h2, 3'h4, 3'h1};
    int err_total = 0;
    int compares = 0;
    int shoots, seed, off;
    event look;

    sbcd_driver i_sbcd_driver (.clk, .reset_n, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .commutation_clock_in,
        .overcurrent_trip, .brake_n, .undervoltage_lockout, .align_end,
        .ramp_end, .pwm_on, .gates, .sense_select, .commutation_clock,
        .bemf_enable, .ramp_source_enable, .undervoltage_flag_n);
    sbcd_bridge i_sbcd_bridge (.clk, .gates, .overload, .overcurrent_trip,
        .shoots);

    // 50 ns clock
    always #25 clk = ~clk;

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One bus transfer, request held until waitrequest is low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd_cap = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    // Expectation notes for the monitor
    task automatic rd(input logic [3:0] a, input logic [31:0] d);
        bus(1'b0, a, 32'h0000_0000);
        q.push_back({2'h0, d});
        ->look;
    endtask
    task automatic pins(input logic [5:0] g);
        q.push_back({2'h1, 26'h0, g});
        ->look;
    endtask
    task automatic flags(input logic [5:0] f);
        q.push_back({2'h2, 26'h0, f});
        ->look;
    endtask

    // One commutation clock period
    task automatic comm();
        commutation_clock_in <= 1'b1;
        w(4);
        commutation_clock_in <= 1'b0;
        w(4);
    endtask

    // Monitor: oldest note against the settled outputs
    always begin
        @(look);
        #1;
        while (q.size() != 0) begin
            e = q.pop_front();
            case (e[33:32])
                2'h0: act = rd_cap;
                2'h1: act = {26'h0, gates};
                default: act = {26'h0, sense_select, undervoltage_flag_n,
                    bemf_enable, ramp_source_enable};
            endcase
            compares++;
            if (act !== e[31:0]) begin
                err_total++;
                $display("wrong value at %0t: got %h, expected %h", $time,
                    act, e[31:0]);
            end
        end
    end

    task automatic results();
        compares++;
        if (shoots != 0) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time,
                shoots, 32'h0000_0000);
        end
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        err_total++;
        results();
    end

    // Main sequence
    initial begin
        seed = 35;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        w(6);
        pins(6'h12);
        flags(6'h04);
        rd(4'h4, 32'(sbcd_pkg::OFF_TIME_RST));
        rd(4'h0, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        // Off-time kept well under a PWM period
        off = 8 + ($random(seed) & 7);
        bus(1'b1, 4'h4, 32'(off));
        rd(4'h4, 32'(off));
        comm();
        pins(6'h12);
        align_end <= 1'b1;
        w(6);
        flags(6'h05);
        for (int i = 0; i < 7; i++) begin
            comm();
            pins(tbl[i % 6]);
            flags({sen[i % 6], 3'b101});
        end
        pwm_on <= 1'b0;
        w(6);
        pins({3'b000, tbl[0][2:0]});
        pwm_on <= 1'b1;
        bus(1'b1, 4'hc, 32'h0000_0000);
        overload <= 1'b1;
        w(2);
        overload <= 1'b0;
        w(4);
        pins({3'b000, tbl[0][2:0]});
        w(off - 5);
        pins({3'b000, tbl[0][2:0]});
        w(6);
        pins(tbl[0]);
        rd(4'hc, 32'h0001_0000);
        brake_n <= 1'b0;
        w(6);
        pins(6'h3f);
        brake_n <= 1'b1;
        bus(1'b1, 4'h0, 32'h0000_0001);
        w(6);
        pins(6'h3f);
        bus(1'b1, 4'h0, 32'h0000_0000);
        ramp_end <= 1'b1;
        w(6);
        flags(6'h16);
        comm();
        pins(tbl[1]);
        rd(4'h8, 32'h0000_0822);
        brake_n <= 1'b0;
        undervoltage_lockout <= 1'b1;
        align_end <= 1'b0;
        ramp_end <= 1'b0;
        w(6);
        pins(6'h07);
        flags(6'h00);
        brake_n <= 1'b1;
        undervoltage_lockout <= 1'b0;
        w(6);
        pins(6'h12);
        flags(6'h04);
        // Software restart from ramp back to align
        align_end <= 1'b1;
        w(6);
        flags(6'h05);
        align_end <= 1'b0;
        bus(1'b1, 4'h0, 32'h0000_0002);
        w(4);
        flags(6'h04);
        rd(4'h0, 32'h0000_0000);
        w(2);
        results();
    end
endmodule
